// ===== pti_stream_intake.sv
// Transmit stream intake: accepts beats from application, frames packets, buffers them.
// Assumes the application drives the stream synchronously on i_clk.
// ****************************************
// Buffer
// ****************************************
module pti_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	input  wire logic             i_clk,
	input  wire logic             i_rst_n,
	input  wire logic             i_valid,
	output logic                  o_ready,
	input  wire logic [WIDTH-1:0] i_data,
	output logic                  o_valid,
	input  wire logic             i_ready,
	output logic [WIDTH-1:0]      o_data,
	output logic [$clog2(DEPTH):0] o_count
);
	localparam int AW = $clog2(DEPTH);
	// Pointer wrap relies on a power-of-two depth
	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
		$error("FIFO depth must be a power of two");
	end
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_ptr_reg;
	logic [AW:0]      rd_ptr_reg;
	logic             push;
	logic             pop;

	// Honest full and empty from pointer distance
	assign o_count = wr_ptr_reg - rd_ptr_reg;
	assign o_ready = o_count != (AW+1)'(DEPTH);
	assign o_valid = o_count != '0;
	assign push    = i_valid && o_ready;
	assign pop     = o_valid && i_ready;
	assign o_data  = mem[rd_ptr_reg[AW-1:0]];

	// Storage written only on accepted pushes
	always_ff @(posedge i_clk) begin
		if (push)
			mem[wr_ptr_reg[AW-1:0]] <= i_data;
	end

	// Pointers
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
		end else begin
			if (push)
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			if (pop)
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
		end
	end
endmodule

module pti_stream_intake
	import pti_pkg::*;
#(
	parameter int DATA_W    = PTI_DATA_W_128,
	parameter int READY_LAT = PTI_READY_LAT_DEF,
	parameter int DEPTH     = PTI_FIFO_DEPTH
) (
	input  wire logic              i_clk,
	input  wire logic              i_reset_n,
	input  wire logic [DATA_W-1:0] i_tx_payload_bus,
	input  wire logic              i_tx_packet_first,
	input  wire logic              i_tx_packet_last,
	input  wire logic              i_tx_upper_qword_unused,
	input  wire logic              i_tx_beat_present,
	output logic                   o_tx_accept_ok,
	output logic                   o_reset_status,
	output logic                   o_frame_error,
	output logic                   o_out_valid,
	input  wire logic              i_out_ready,
	output logic [DATA_W-1:0]      o_out_data,
	output logic                   o_out_first,
	output logic                   o_out_last,
	output logic                   o_out_upper_unused
);
	// Elaboration checks on the configurable widths and latency
	if (DATA_W != PTI_DATA_W_64 && DATA_W != PTI_DATA_W_128) begin : g_bad_width
		$error("Data width must be 64 or 128");
	end
	if (READY_LAT < 1 || READY_LAT > 2) begin : g_bad_latency
		$error("Ready latency must be 1 or 2");
	end
	// Headroom below needs the buffer deeper than the ready round trip
	if (DEPTH <= READY_LAT + 2) begin : g_bad_depth
		$error("Buffer too shallow for the ready latency");
	end

	// ****************************************
	// Reset synchroniser
	// ****************************************
	logic rst_meta_reg;
	logic rst_sync_reg;
	logic rst_n;
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end
	assign rst_n = rst_sync_reg;

	// Status stays high until intake is out of reset
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n)
			o_reset_status <= 1'b1;
		else
			o_reset_status <= !rst_n;
	end

	// ****************************************
	// Ready generation and latency pipeline
	// ****************************************
	localparam int FIFO_W = $bits(pti_beat_s);
	localparam int CW     = $clog2(DEPTH) + 1;
	logic [CW-1:0]        fifo_count;
	logic                 fifo_in_ready;
	logic [READY_LAT-1:0] rdy_pipe_reg;
	logic                 ready_cycle;
	logic                 take;
	pti_beat_s            beat_in;
	pti_beat_s            beat_out;

	// Headroom: room is seen READY_LAT+1 cycles late, so that many beats may follow.
	// Trading buffer slack for a registered ready gives clean timing.
	logic room;
	assign room = fifo_count <= CW'(DEPTH - READY_LAT - 2);

	// Registered ready, throttled by buffer room
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n)
			o_tx_accept_ok <= PTI_RESET_READY;
		else
			o_tx_accept_ok <= room;
	end

	// Ready delayed by the configured latency marks ready cycles
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n)
			rdy_pipe_reg <= '0;
		else if (READY_LAT == 1)
			rdy_pipe_reg <= READY_LAT'(o_tx_accept_ok);
		else
			rdy_pipe_reg <= READY_LAT'({rdy_pipe_reg, o_tx_accept_ok});
	end
	assign ready_cycle = rdy_pipe_reg[READY_LAT-1];

	// Capture only when valid lands in a ready cycle
	assign take = i_tx_beat_present && ready_cycle && fifo_in_ready;

	// ****************************************
	// Framing
	// ****************************************
	pti_state_e state_reg;
	logic       bad_beat;
	// Markers considered only with valid nested start or orphan beat is bad
	assign bad_beat = take && ((state_reg == PTI_IN_PKT) == i_tx_packet_first);

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n)
			state_reg <= PTI_IDLE;
		else if (take) begin
			case (state_reg)
				PTI_IDLE: begin
					if (i_tx_packet_first && !i_tx_packet_last)
						state_reg <= PTI_IN_PKT;
				end
				PTI_IN_PKT: begin
					if (i_tx_packet_last)
						state_reg <= PTI_IDLE;
				end
				default: state_reg <= PTI_IDLE;
			endcase
		end
	end

	// Sticky framing error; an out-of-pattern packet leaves intake stuck until reset
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n)
			o_frame_error <= 1'b0;
		else if (bad_beat)
			o_frame_error <= 1'b1;
	end

	// Build carrier; empty flag kept only on end beat of a 128-bit bus
	always_comb begin
		beat_in              = '0;
		beat_in.data         = PTI_DATA_W_128'(i_tx_payload_bus);
		beat_in.first        = i_tx_packet_first;
		beat_in.last         = i_tx_packet_last;
		beat_in.upper_unused = (DATA_W == PTI_DATA_W_128) && i_tx_packet_last && i_tx_upper_qword_unused;
		if (beat_in.upper_unused)
			beat_in.data[PTI_DATA_W_128-1:PTI_QWORD_W] = '0;
	end

	pti_fifo #(
		.WIDTH (FIFO_W),
		.DEPTH (DEPTH)
	) u_fifo (
		.i_clk   (i_clk),
		.i_rst_n (rst_n),
		.i_valid (take && !o_frame_error),
		.o_ready (fifo_in_ready),
		.i_data  (beat_in),
		.o_valid (o_out_valid),
		.i_ready (i_out_ready),
		.o_data  (beat_out),
		.o_count (fifo_count)
	);

	assign o_out_data         = beat_out.data[DATA_W-1:0];
	assign o_out_first        = beat_out.first;
	assign o_out_last         = beat_out.last;
	assign o_out_upper_unused = beat_out.upper_unused;

	// ****************************************
	// Checks
	// ****************************************
	a_ready_tracks_room: assert property (@(posedge i_clk) disable iff (!rst_n)
		(fifo_count == CW'(DEPTH - 1)) |=> !o_tx_accept_ok) else $error("ready kept on full buffer");
	a_no_overflow_take: assert property (@(posedge i_clk) disable iff (!rst_n)
		(i_tx_beat_present && ready_cycle) |-> fifo_in_ready) else $error("beat lost to full buffer");
	a_latency_marks: assert property (@(posedge i_clk) disable iff (!rst_n)
		ready_cycle |-> $past(o_tx_accept_ok, READY_LAT)) else $error("ready cycle without ready");
	a_capture_needs: assert property (@(posedge i_clk) disable iff (!rst_n)
		(i_tx_beat_present && !ready_cycle) |=> fifo_count <= $past(fifo_count))
		else $error("capture outside ready cycle");
	a_err_blocks: assert property (@(posedge i_clk) disable iff (!rst_n)
		o_frame_error |=> fifo_count <= $past(fifo_count)) else $error("beat stored after framing error");
	a_err_sticky: assert property (@(posedge i_clk) disable iff (!rst_n)
		$past(bad_beat) |-> o_frame_error) else $error("bad framing not flagged");
	a_empty_on_last: assert property (@(posedge i_clk) disable iff (!rst_n)
		beat_in.upper_unused |-> (beat_in.last && DATA_W == PTI_DATA_W_128)) else $error("empty off end beat");
	a_start_enters: assert property (@(posedge i_clk) disable iff (!rst_n)
		(take && state_reg == PTI_IDLE && i_tx_packet_first && !i_tx_packet_last) |=> state_reg == PTI_IN_PKT)
		else $error("start beat not framed");
	a_end_leaves: assert property (@(posedge i_clk) disable iff (!rst_n)
		(take && i_tx_packet_last) |=> state_reg == PTI_IDLE) else $error("end beat not framed");
	c_single_beat: cover property (@(posedge i_clk) disable iff (!rst_n)
		take && i_tx_packet_first && i_tx_packet_last);
	c_throttle: cover property (@(posedge i_clk) disable iff (!rst_n)
		$fell(o_tx_accept_ok));
	c_upper_empty: cover property (@(posedge i_clk) disable iff (!rst_n)
		take && beat_in.upper_unused);
	c_frame_error: cover property (@(posedge i_clk) disable iff (!rst_n)
		$rose(o_frame_error));
endmodule

// ===== pti_pkg.sv
// Package for the transmit stream intake: widths, latency and beat carrier.
// Assumes a single clock domain; included before all design modules.
package pti_pkg;
	// ****************************************
	// Sizes and timing
	// ****************************************
	localparam int PTI_DATA_W_64     = 64;
	localparam int PTI_DATA_W_128    = 128;
	localparam int PTI_READY_LAT_DEF = 2;
	localparam int PTI_FIFO_DEPTH    = 32;
	localparam int PTI_QWORD_W       = 64;
	localparam logic PTI_RESET_READY = 1'b0;

	// One accepted beat as it travels through the buffer
	typedef struct packed {
		logic [PTI_DATA_W_128-1:0] data;
		logic                      first;
		logic                      last;
		logic                      upper_unused;
	} pti_beat_s;

	// Packet framing state
	typedef enum logic [0:0] {
		PTI_IDLE    = 1'b0,
		PTI_IN_PKT  = 1'b1
	} pti_state_e;
endpackage

// ===== pti_app_model.sv
// Application-side model: queued beats go out only in ready cycles.
// Assumes the intake's ready latency equals LAT and a shared clock.
module pti_app_model
	import pti_pkg::*;
#(
	parameter int LAT = 2
) (
	input  wire logic i_clk,
	input  wire logic i_reset_status,
	input  wire logic i_accept_ok,
	input  wire logic i_slow,
	output pti_beat_s o_beat,
	output logic      o_present
);
	timeunit 1ns;
	timeprecision 1ps;
	// ********
	// Sender
	// ********
	pti_beat_s    q[$];
	logic [LAT:0] hist = '0;
	logic         in_pkt = 1'b0;
	initial o_present = 1'b0;
	initial o_beat = '0;
	// Retire the taken beat, then send only where ready was seen LAT edges back
	always @(posedge i_clk) begin
		if (o_present && q.size() > 0) begin
			in_pkt = !q[0].last;
			void'(q.pop_front());
		end
		if (i_reset_status)
			in_pkt = 1'b0;
		hist = {hist[LAT-1:0], i_accept_ok};
		// Slow mode leaves one idle cycle after each packet end
		if (!i_reset_status && hist[LAT-1] && q.size() > 0 && !(i_slow && !in_pkt && o_present)) begin
			o_present <= 1'b1;
			o_beat    <= q[0];
		end else begin
			o_present   <= 1'b0;
			o_beat.data <= ~o_beat.data; // Idle bus inverts the data each cycle, so every second idle cycle repeats the last beat's data
		end
	end
endmodule

// ===== tb.sv
// Testbench: the model feeds the intake, the drain side is checked in order.
// Runs a 128-bit latency-2 build and a 64-bit latency-1 build side by side, 32-deep buffers.
module tb
	import pti_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic       i_clk = 1'b0;
	logic       i_reset_n = 1'b0;
	logic       i_out_ready = 1'b0;
	logic       slow = 1'b0;
	logic       mon_on = 1'b1;
	logic       ok, rst_st, ferr, out_valid, present;
	logic       ok2, rst2, ferr2, out_valid2, present2, f2, l2, u2;
	logic       timed_out = 1'b0;
	logic [63:0] d2;
	pti_beat_s  beat2;
	pti_beat_s  exp2_q[$];
	logic [7:0] seq = 8'h01;
	pti_beat_s  beat, ob;
	pti_beat_s  exp_q[$];
	int         n_fail = 0;
	int         total_checks = 0;
	// ********
	// Design and partner
	// ********
	pti_stream_intake #(.DATA_W(PTI_DATA_W_128), .READY_LAT(2), .DEPTH(PTI_FIFO_DEPTH)) dut (
		.i_clk(i_clk), .i_reset_n(i_reset_n), .i_tx_payload_bus(beat.data),
		.i_tx_packet_first(beat.first), .i_tx_packet_last(beat.last),
		.i_tx_upper_qword_unused(beat.upper_unused), .i_tx_beat_present(present),
		.o_tx_accept_ok(ok), .o_reset_status(rst_st), .o_frame_error(ferr),
		.o_out_valid(out_valid), .i_out_ready(i_out_ready), .o_out_data(ob.data),
		.o_out_first(ob.first), .o_out_last(ob.last), .o_out_upper_unused(ob.upper_unused));
	pti_app_model #(.LAT(2)) app (.i_clk(i_clk), .i_reset_status(rst_st), .i_accept_ok(ok),
		.i_slow(slow), .o_beat(beat), .o_present(present));
	pti_stream_intake #(.DATA_W(PTI_DATA_W_64), .READY_LAT(1), .DEPTH(PTI_FIFO_DEPTH)) dut2 (
		.i_clk(i_clk), .i_reset_n(i_reset_n), .i_tx_payload_bus(beat2.data[63:0]),
		.i_tx_packet_first(beat2.first), .i_tx_packet_last(beat2.last),
		.i_tx_upper_qword_unused(beat2.upper_unused), .i_tx_beat_present(present2),
		.o_tx_accept_ok(ok2), .o_reset_status(rst2), .o_frame_error(ferr2),
		.o_out_valid(out_valid2), .i_out_ready(i_out_ready), .o_out_data(d2),
		.o_out_first(f2), .o_out_last(l2), .o_out_upper_unused(u2));
	pti_app_model #(.LAT(1)) app2 (.i_clk(i_clk), .i_reset_status(rst2), .i_accept_ok(ok2),
		.i_slow(slow), .o_beat(beat2), .o_present(present2));
	initial forever #5 i_clk = ~i_clk;
	// ********
	// Checking helpers
	// ********
	task automatic chk_beat(input pti_beat_s a, input pti_beat_s e);
		total_checks++;
		if (a !== e) begin
			n_fail++;
			$display("BAD %0t %h %h", $time, a, e);
		end
	endtask
	task automatic chk_bit(input logic a, input logic e);
		total_checks++;
		if (a !== e) begin
			n_fail++;
			$display("BAD %0t %h %h", $time, a, e);
		end
	endtask
	task automatic results();
		if (n_fail == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Queue one packet of n beats on both builds; the narrow build never carries an upper qword
	task automatic put(input int n, input logic un, input logic e = 1'b1);
		pti_beat_s b;
		for (int i = 0; i < n; i++) begin
			b.data = {{8{seq}}, {8{~seq}}};
			seq++;
			b.first = i == 0;
			b.last = i == n - 1;
			b.upper_unused = un && b.last;
			app.q.push_back(b);
			app2.q.push_back(b);
			if (b.upper_unused)
				b.data[127:64] = '0;
			if (e)
				exp_q.push_back(b);
			b.data[127:64] = '0;
			b.upper_unused = 1'b0;
			if (e)
				exp2_q.push_back(b);
		end
	endtask
	// A bound that runs out counts as a mismatch and ends the run
	task automatic bound(input int k, input int lim);
		if (k == lim) begin
			n_fail++;
			timed_out = 1'b1;
		end
	endtask
	task automatic drain(input int lim);
		int k;
		for (k = 0; k < lim && exp_q.size() + app.q.size() + exp2_q.size() + app2.q.size() > 0; k++)
			@(posedge i_clk);
		bound(k, lim);
		repeat (4) @(posedge i_clk);
	endtask
	// In-order drain check against the expected beats
	always @(posedge i_clk) begin
		if (mon_on && out_valid === 1'b1 && i_out_ready) begin
			if (exp_q.size() == 0)
				chk_bit(1'b1, 1'b0);
			else
				chk_beat(ob, exp_q.pop_front());
		end
	end
	// Same check on the narrow build; its data is padded with a zero upper qword, and the empty flag must read as zero
	always @(posedge i_clk) begin
		if (mon_on && out_valid2 === 1'b1 && i_out_ready) begin
			if (exp2_q.size() == 0)
				chk_bit(1'b1, 1'b0);
			else
				chk_beat({64'h0, d2, f2, l2, u2}, exp2_q.pop_front());
		end
	end
	// ********
	// Scenarios
	// ********
	task automatic do_reset();
		i_reset_n <= 1'b0;
		repeat (6) @(posedge i_clk);
		chk_bit(ok, PTI_RESET_READY);
		chk_bit(rst_st, 1'b1);
		chk_bit(ferr, 1'b0);
		chk_bit(ok2, PTI_RESET_READY);
		chk_bit(rst2, 1'b1);
		chk_bit(ferr2, 1'b0);
		app.q.delete();
		exp_q.delete();
		app2.q.delete();
		exp2_q.delete();
		i_reset_n <= 1'b1;
		repeat (4) @(posedge i_clk);
		chk_bit(rst_st, 1'b0);
		chk_bit(rst2, 1'b0);
	endtask
	task automatic s_basic();
		i_out_ready <= 1'b1;
		for (int s = 0; s < 2; s++) begin
			slow <= s[0];
			put(1, 1'b1);
			put(3, 1'b0);
			put(2, 1'b1);
			drain(200);
		end
		chk_bit(out_valid, 1'b0);
		chk_bit(out_valid2, 1'b0);
	endtask
	// Stalled drain: ready must drop before the buffer overflows
	task automatic s_fill();
		int k;
		i_out_ready <= 1'b0;
		put(40, 1'b0);
		for (k = 0; k < 200 && (ok !== 1'b0 || ok2 !== 1'b0); k++) @(posedge i_clk);
		bound(k, 200);
		repeat (10) @(posedge i_clk);
		chk_bit(ok, 1'b0);
		chk_bit(ok2, 1'b0);
		chk_bit(app.q.size() >= 8, 1'b1);
		chk_bit(app2.q.size() >= 8, 1'b1);
		i_out_ready <= 1'b1;
		drain(400);
	endtask
	// Nested start, then a stray beat: intake hangs until reset
	task automatic s_err();
		pti_beat_s b;
		int k;
		for (int e = 0; e < 2; e++) begin
			mon_on <= 1'b0;
			b = '0;
			b.first = e == 0;
			app.q.push_back(b);
			app2.q.push_back(b);
			b.last = 1'b1;
			app.q.push_back(b);
			app2.q.push_back(b);
			for (k = 0; k < 50 && (ferr !== 1'b1 || ferr2 !== 1'b1); k++) @(posedge i_clk);
			bound(k, 50);
			repeat (10) @(posedge i_clk);
			i_out_ready <= 1'b0;
			put(2, 1'b0, 1'b0);
			drain(100);
			chk_bit(ferr, 1'b1);
			chk_bit(out_valid, 1'b0);
			chk_bit(ferr2, 1'b1);
			chk_bit(out_valid2, 1'b0);
			do_reset();
			mon_on <= 1'b1;
			i_out_ready <= 1'b1;
			put(2, 1'b1);
			drain(100);
		end
	endtask
	// Scenarios, a spent bound or the watchdog: whichever ends first leads to the verdict
	initial begin
		fork
			begin
				do_reset();
				s_basic();
				s_fill();
				s_err();
			end
			wait (timed_out);
			begin
				#500us;
				n_fail++;
			end
		join_any
		results();
	end
endmodule
